// ### cgt_far_model.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------------
// Panel counter and pulled-up digit bus on the far side
// ----------------------------------------------------------------------
// The counter powers up holding an arbitrary total, not zero.
module cgt_far_model
    import cgt_pkg::*;
#(
    parameter logic [TOT_W-1:0] P_PRESET = 24'h654321
) (
    input  wire logic             i_sys_clk,
    input  wire logic             i_reset_n,
    input  wire logic             i_run_n,
    input  wire logic             i_clear_n,
    input  wire logic [DIG_W-1:0] i_bus_oe,
    output logic [TOT_W-1:0]      o_bcd_total,
    output logic [DIG_W-1:0]      o_bus_lines
);
    // Pull-ups lift every line that no collector pulls low.
    assign o_bus_lines = ~i_bus_oe;

    function automatic logic [TOT_W-1:0] bcd_inc(logic [TOT_W-1:0] v);
        logic c;
        c = 1'b1;
        for (int d = 0; d < NDIG; d++) begin
            if (c && v[d*4 +: 4] == 4'h9) begin
                v[d*4 +: 4] = 4'h0;
            end else if (c) begin
                v[d*4 +: 4] = v[d*4 +: 4] + 4'h1;
                c = 1'b0;
            end
        end
        return v;
    endfunction

    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_bcd_total <= P_PRESET;
        end else if (!i_clear_n) begin
            o_bcd_total <= '0;
        end else if (!i_run_n) begin
            o_bcd_total <= bcd_inc(o_bcd_total);
        end
    end
endmodule // cgt_far_model

// ### cgt_pkg.sv
package cgt_pkg;

    // ------------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------------
    localparam int unsigned CLK_HZ     = 10_000_000;
    localparam int unsigned CLK_NS     = 1_000_000_000 / CLK_HZ;
    localparam int unsigned CLR_NS     = 250;
    localparam int unsigned CLR_CYC    = (CLR_NS + CLK_NS - 1) / CLK_NS;
    localparam int unsigned UNIT_US    = 10;
    localparam int unsigned UNIT_CYC   = UNIT_US * (CLK_HZ / 1_000_000);
    localparam int unsigned VIEW_MS    = 1000;
    localparam int unsigned VIEW_UNITS = VIEW_MS * 1000 / UNIT_US;

    // Gate length in 10 us units, one decade per select code up to code 6; code 7 repeats code 6.
    localparam logic [19:0] GATE_UNITS [8] = '{
        20'h00001, 20'h0000a, 20'h00064, 20'h003e8,
        20'h02710, 20'h186a0, 20'hf4240, 20'hf4240
    };

    // ------------------------------------------------------------------
    // Buffer layout
    // ------------------------------------------------------------------
    localparam int unsigned NDIG   = 6;
    localparam int unsigned DIG_W  = 4;
    localparam int unsigned TOT_W  = NDIG * DIG_W;
    localparam int unsigned FLAG_W = 2;
    localparam int unsigned BUF_W  = TOT_W + FLAG_W;
    localparam int unsigned NLANE  = NDIG + 1;

    // ------------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [4:0] REG_CTRL     = 5'h00;
    localparam logic [4:0] REG_STATUS   = 5'h04;
    localparam logic [4:0] REG_DATA     = 5'h08;
    localparam logic [4:0] REG_IRQ_STAT = 5'h0c;
    localparam logic [4:0] REG_IRQ_MASK = 5'h10;
    localparam int unsigned CTRL_LATCH  = 0;
    localparam int unsigned CTRL_TRIG   = 1;
    localparam int unsigned IRQ_RUN_END = 0;
    localparam int unsigned IRQ_VIEW_END = 1;
    localparam int unsigned IRQ_W       = 2;

    typedef enum logic [3:0] {
        ST_IDLE  = 4'h1,
        ST_CLEAR = 4'h2,
        ST_RUN   = 4'h4,
        ST_VIEW  = 4'h8
    } cgt_state_t;

    typedef struct packed {
        cgt_state_t         st;
        logic               pend;
        logic               on_s1;
        logic               on_s2;
        logic               on_d;
        logic [2:0]         sel_s1;
        logic [2:0]         sel_s2;
        logic [BUF_W-1:0]   tot_s1;
        logic [BUF_W-1:0]   tot_s2;
        logic [NLANE-1:0]   en_s1;
        logic [NLANE-1:0]   en_s2;
        logic [DIG_W-1:0]   bin_s1;
        logic [DIG_W-1:0]   bin_s2;
        logic [15:0]        pre;
        logic [19:0]        cnt;
        logic [19:0]        gate;
        logic [BUF_W-1:0]   buf_q;
        logic               latch;
        logic               hold;
        logic               blank;
        logic               run_n;
        logic               clr_n;
        logic [DIG_W-1:0]   bus_oe;
        logic [DIG_W-1:0]   bus_do;
        logic               waitreq;
        logic [31:0]        rdata;
        logic [IRQ_W-1:0]   irq_stat;
        logic [IRQ_W-1:0]   irq_mask;
        logic               irq;
    } cgt_regs_t;

endpackage

// ### cgt_sequencer.sv
`timescale 1ns/1ps

// What this block does
// RULE_01: Six BCD digits, one at a time, four lines.
// RULE_02: Seventh word carries power-fail and overscale flags.
// RULE_03: One enable per digit gates it onto bus.
// RULE_04: Trigger at any moment starts one timed gate.
// RULE_05: Run gate admits counts only while measuring.
// RULE_06: One-second viewing pause follows every gate.
// RULE_07: Held-low trigger repeats gate and pause forever.
// RULE_08: Three select bits choose 10 us to 10 s.
// RULE_09: 250 ns clear pulse just before each gate.
// RULE_10: Blank and follow/hold outputs are complementary; the code keeps this in non-latching mode only.
// RULE_11: Non-latching: dark during gate, lit during pause.
// RULE_12: Latching mode never blanks the display.
// RULE_13: Latching: latches follow at end of gate.
// RULE_14: Latching: capture at pause end, then clear.
// RULE_15: Buffer holds one total, parallel or nibble.
// RULE_16: Gate lengths step by decades.
// RULE_17: Ascending codes, lowest shortest, unused is longest.
module cgt_sequencer
    import cgt_pkg::*;
#(
    parameter int unsigned P_UNIT_CYC   = UNIT_CYC,
    parameter int unsigned P_VIEW_UNITS = VIEW_UNITS
) (
    input  wire logic              i_sys_clk,
    input  wire logic              i_reset_n,
    input  wire logic              i_on_off_n,
    input  wire logic [2:0]        i_gate_sel,
    input  wire logic [TOT_W-1:0]  i_bcd_total,
    input  wire logic              i_power_fail,
    input  wire logic              i_overscale,
    input  wire logic [NLANE-1:0]  i_dig_en_n,
    input  wire logic [DIG_W-1:0]  i_bus_in,
    output logic [DIG_W-1:0]       o_bus_out,
    output logic [DIG_W-1:0]       o_bus_oe,
    output logic                   o_run_n,
    output logic                   o_clear_n,
    output logic                   o_blank,
    output logic                   o_hold,
    input  wire logic [4:0]        i_avs_address,
    input  wire logic              i_avs_read,
    input  wire logic              i_avs_write,
    input  wire logic [31:0]       i_avs_writedata,
    input  wire logic [3:0]        i_avs_byteenable,
    output logic [31:0]            o_avs_readdata,
    output logic                   o_avs_waitrequest,
    output logic                   o_irq
);

    localparam cgt_regs_t RST = '{
        st:      ST_IDLE,
        on_s1:   1'b1,
        on_s2:   1'b1,
        on_d:    1'b1,
        en_s1:   7'h7f,
        en_s2:   7'h7f,
        blank:   1'b1,
        run_n:   1'b1,
        clr_n:   1'b1,
        waitreq: 1'b1,
        default: '0
    };

    cgt_regs_t r;
    cgt_regs_t n;
    logic      tick;
    logic      again;
    logic      req;
    logic      take;
    logic [DIG_W-1:0] lane_acc [NLANE+1];

    // ------------------------------------------------------------------
    // Open-collector lanes
    // ------------------------------------------------------------------
    // A one bit pulls its line low; several enables at once simply
    // wire-AND on the bus, which is how wider groupings are read.
    assign lane_acc[0] = '0;
    for (genvar g = 0; g < NLANE; g++) begin : g_lane
        logic [DIG_W-1:0] word;
        if (g < NDIG) begin : g_dig
            assign word = r.buf_q[g*DIG_W +: DIG_W];         // see RULE_01
        end else begin : g_flag
            assign word = {2'h0, r.buf_q[BUF_W-1 -: FLAG_W]}; // see RULE_02
        end
        assign lane_acc[g+1] = lane_acc[g]
                             | (r.en_s2[g] ? '0 : word);     // see RULE_03
    end

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        n = r;
        n.on_s1  = i_on_off_n;
        n.on_s2  = r.on_s1;
        n.on_d   = r.on_s2;
        n.sel_s1 = i_gate_sel;
        n.sel_s2 = r.sel_s1;
        n.tot_s1 = {i_overscale, i_power_fail, i_bcd_total};
        n.tot_s2 = r.tot_s1;
        n.en_s1  = i_dig_en_n;
        n.en_s2  = r.en_s1;
        n.bin_s1 = i_bus_in;
        n.bin_s2 = r.bin_s1;

        tick  = (r.pre == 16'(P_UNIT_CYC - 1));
        n.pre = tick ? 16'h0 : r.pre + 16'h1;
        again = r.pend || !r.on_s2;

        case (r.st)
            ST_IDLE: begin
                n.cnt = 20'h0;
                if (again) begin                             // see RULE_04
                    n.st   = ST_CLEAR;
                    n.pend = 1'b0;
                end
            end
            ST_CLEAR: begin
                n.cnt = r.cnt + 20'h1;
                if (r.cnt == 20'(CLR_CYC - 1)) begin         // see RULE_09
                    n.st   = ST_RUN;
                    n.cnt  = 20'h0;
                    n.pre  = 16'h0;
                    n.gate = GATE_UNITS[r.sel_s2]; // see RULE_16, RULE_17
                end
            end
            ST_RUN: begin
                if (tick) begin
                    n.cnt = r.cnt + 20'h1;
                    if (r.cnt == r.gate - 20'h1) begin       // see RULE_08
                        n.st  = ST_VIEW;                     // see RULE_06
                        n.cnt = 20'h0;
                        n.irq_stat[IRQ_RUN_END] = 1'b1;
                    end
                end
            end
            ST_VIEW: begin
                if (tick) begin
                    n.cnt = r.cnt + 20'h1;
                    if (r.cnt == 20'(P_VIEW_UNITS - 1)) begin
                        n.cnt = 20'h0;
                        n.irq_stat[IRQ_VIEW_END] = 1'b1;
                        if (again) begin                     // see RULE_07
                            n.st   = ST_CLEAR;
                            n.pend = 1'b0;
                        end else begin
                            n.st = ST_IDLE;
                        end
                    end
                end
            end
            default: begin
                n.st = ST_IDLE;
            end
        endcase

        // Bus slave: a write lands on the edge that ends the wait.
        req       = i_avs_read || i_avs_write;
        take      = req && !r.waitreq;
        n.waitreq = !(req && r.waitreq);
        if (req && r.waitreq) begin
            case (i_avs_address)
                REG_CTRL:     n.rdata = {30'h0, 1'b0, r.latch};
                REG_STATUS:   n.rdata = {19'h0, r.st, r.pend, r.on_s2,
                                         r.sel_s2, r.bin_s2};
                REG_DATA:     n.rdata = {6'h0, r.buf_q};     // see RULE_15
                REG_IRQ_STAT: n.rdata = {30'h0, r.irq_stat};
                REG_IRQ_MASK: n.rdata = {30'h0, r.irq_mask};
                default:      n.rdata = 32'h0;
            endcase
        end
        if (take && i_avs_write && i_avs_byteenable[0]) begin
            case (i_avs_address)
                REG_CTRL: begin
                    n.latch = i_avs_writedata[CTRL_LATCH];
                    if (i_avs_writedata[CTRL_TRIG]) begin
                        n.pend = 1'b1;
                    end
                end
                REG_IRQ_STAT: begin
                    // Events of this same edge are ORed back in below.
                    n.irq_stat = r.irq_stat
                               & ~i_avs_writedata[IRQ_W-1:0];
                    if (r.st == ST_RUN && n.st == ST_VIEW) begin
                        n.irq_stat[IRQ_RUN_END] = 1'b1;
                    end
                    if (r.st == ST_VIEW && n.st != ST_VIEW) begin
                        n.irq_stat[IRQ_VIEW_END] = 1'b1;
                    end
                end
                REG_IRQ_MASK: n.irq_mask = i_avs_writedata[IRQ_W-1:0];
                default: begin
                end
            endcase
        end

        // A trigger edge never gets lost, but an edge that starts a gate
        // in this very cycle is used up by it; storing it as well would
        // run a second gate that nobody asked for.
        if (r.on_d && !r.on_s2
            && !(n.st == ST_CLEAR && r.st != ST_CLEAR)) begin // see RULE_04
            n.pend = 1'b1;
        end

        n.run_n = (n.st != ST_RUN);                          // see RULE_05
        n.clr_n = (n.st != ST_CLEAR);                        // see RULE_09
        if (n.latch) begin
            n.blank = 1'b0;                                  // see RULE_12
            n.hold  = (n.st != ST_VIEW);                     // see RULE_13
        end else begin
            n.blank = (n.st != ST_VIEW);                     // see RULE_11
            n.hold  = !n.blank;                              // see RULE_10
        end
        // The synchronised total is only trusted once the counter has
        // stopped, which is when the hold edge samples it in latching mode.
        if (!r.hold) begin
            n.buf_q = r.tot_s2;                              // see RULE_14
        end
        n.bus_oe = lane_acc[NLANE];
        n.bus_do = '0;
        n.irq    = |(n.irq_stat & n.irq_mask);
    end

    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            r <= RST;
        end else begin
            r <= n;
        end
    end

    assign o_bus_out         = r.bus_do;
    assign o_bus_oe          = r.bus_oe;
    assign o_run_n           = r.run_n;
    assign o_clear_n         = r.clr_n;
    assign o_blank           = r.blank;
    assign o_hold            = r.hold;
    assign o_avs_readdata    = r.rdata;
    assign o_avs_waitrequest = r.waitreq;
    assign o_irq             = r.irq;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (!i_reset_n);

    a_clear_width: // see RULE_09
    assert property ($fell(o_clear_n) |-> !o_clear_n[*3] ##1 o_clear_n)
        else $error("clear pulse is not three cycles");
    a_run_after_clr: // see RULE_09
    assert property ($rose(o_clear_n) |-> $fell(o_run_n))
        else $error("run gate does not follow clear");
    a_trigger_run: // see RULE_04
    assert property (r.st == ST_IDLE && r.pend
                     |=> r.st == ST_CLEAR ##3 r.st == ST_RUN)
        else $error("trigger did not start a gate");
    a_view_after: // see RULE_06
    assert property ($rose(o_run_n) |-> r.st == ST_VIEW && o_clear_n)
        else $error("no viewing pause after gate");
    a_repeat_held: // see RULE_07
    assert property (r.st == ST_VIEW && n.st != ST_VIEW && !r.on_s2
                     |=> r.st == ST_CLEAR)
        else $error("held trigger did not repeat");
    a_gate_load: // see RULE_17
    assert property (r.st == ST_CLEAR && n.st == ST_RUN
                     |=> r.gate == GATE_UNITS[$past(r.sel_s2)])
        else $error("wrong gate length loaded");
    a_never_blank: // see RULE_12
    assert property (r.latch |-> !o_blank)
        else $error("display blanked in latching mode");
    a_dark_run: // see RULE_11
    assert property (!r.latch && !o_run_n |-> o_blank)
        else $error("display lit during gate");
    a_compl_out: // see RULE_10
    assert property (!r.latch |-> o_hold != o_blank)
        else $error("blank and hold not complementary");
    a_follow_end: // see RULE_13
    assert property (r.latch && $rose(o_run_n) |-> !o_hold)
        else $error("latches not released after gate");
    a_capture_end: // see RULE_14
    assert property (r.latch && $fell(r.st == ST_VIEW) |-> o_hold)
        else $error("latches not capturing after pause");
    a_buf_stable: // see RULE_15
    assert property (o_hold |=> $stable(r.buf_q))
        else $error("buffer changed while held");
    a_digit_lane: // see RULE_01
    assert property (r.en_s2 == 7'h7e
                     |=> o_bus_oe == $past(r.buf_q[3:0]))
        else $error("first digit not on bus");
    a_flag_lane: // see RULE_02
    assert property (r.en_s2 == 7'h3f
                     |=> o_bus_oe == {2'h0, $past(r.buf_q[25:24])})
        else $error("flag word not on bus");

    c_repeat: cover property (r.st == ST_VIEW ##1 r.st == ST_CLEAR);
    c_latch_gate: cover property (r.latch && $rose(o_run_n));
    c_irq: cover property ($rose(o_irq));
    c_flag_read: cover property (r.en_s2 == 7'h3f ##1 o_bus_oe != 4'h0);

endmodule // cgt_sequencer

// ### tb_top.sv
`timescale 1ns/1ps

module tb_top;
    import cgt_pkg::*;
    localparam int PU = 2;
    localparam int PV = 5;
    localparam logic [TOT_W-1:0] PRESET = 24'h654321;
    logic             clk = 1'b0;
    logic             reset_n = 1'b0;
    logic             on_off_n = 1'b1;
    logic [2:0]       gate_sel = 3'h0;
    logic             pf = 1'b1;
    logic             ov = 1'b0;
    logic [NLANE-1:0] dig_en_n = 7'h7f;
    logic [4:0]       avs_address = 5'h00;
    logic             avs_read = 1'b0;
    logic             avs_write = 1'b0;
    logic [31:0]      avs_writedata = 32'h0;
    logic [31:0]      rd, avs_readdata;
    logic [TOT_W-1:0] bcd_total;
    logic [DIG_W-1:0] bus_lines, bus_oe, bus_out, lane_w;
    logic             run_n, clear_n, blank, hold, irq, waitreq;
    int               errors = 0;
    int               num_checks = 0;
    int               cyc = 0;
    int               gap;

    always #50 clk = ~clk;

    cgt_sequencer #(.P_UNIT_CYC(PU), .P_VIEW_UNITS(PV)) dut (
        .i_sys_clk(clk), .i_reset_n(reset_n), .i_on_off_n(on_off_n),
        .i_gate_sel(gate_sel), .i_bcd_total(bcd_total),
        .i_power_fail(pf), .i_overscale(ov), .i_dig_en_n(dig_en_n),
        .i_bus_in(bus_lines), .o_bus_out(bus_out), .o_bus_oe(bus_oe),
        .o_run_n(run_n), .o_clear_n(clear_n), .o_blank(blank),
        .o_hold(hold), .i_avs_address(avs_address),
        .i_avs_read(avs_read), .i_avs_write(avs_write),
        .i_avs_writedata(avs_writedata), .i_avs_byteenable(4'h1),
        .o_avs_readdata(avs_readdata), .o_avs_waitrequest(waitreq),
        .o_irq(irq));

    cgt_far_model #(.P_PRESET(PRESET)) far (
        .i_sys_clk(clk), .i_reset_n(reset_n), .i_run_n(run_n),
        .i_clear_n(clear_n), .i_bus_oe(bus_oe),
        .o_bcd_total(bcd_total), .o_bus_lines(bus_lines));

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    task automatic report_and_stop;
        $display("Checks %0d, errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // The whole run, longest gate included, plus margin; a hang ends here instead of running on.
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            errors++;
            report_and_stop();
        end
    end

    task automatic check(string name, logic [31:0] exp, logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask

    function automatic logic [TOT_W-1:0] to_bcd(int v);
        logic [TOT_W-1:0] r;
        for (int d = 0; d < NDIG; d++) begin
            r[d*4 +: 4] = 4'(v % 10);
            v = v / 10;
        end
        return r;
    endfunction

    task automatic bus(logic wr, logic [4:0] a, logic [31:0] wd);
        int n;
        n = 0;
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= wd;
        avs_write <= wr;
        avs_read <= !wr;
        do begin
            @(posedge clk);
            n++;
        end while (waitreq !== 1'b0 && n < 100);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        if (n >= 100) errors++;
    endtask

    task automatic rchk(string name, logic [4:0] a, logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        check(name, exp, rd);
    endtask

    task automatic wait_idle;
        int n;
        n = 0;
        do begin
            bus(1'b0, REG_STATUS, 32'h0);
            n++;
        end while (rd[12:9] !== 4'h1 && n < 200);
    endtask

    // Measures one clear, gate and pause sequence at the output pins.
    task automatic run_cycle(int code, logic latch);
        int n, bad;
        n = 0;
        bad = 0;
        // After a pause that ran straight into a new clear, the falling
        // edge that ended it already shows the first clear cycle.
        if (clk) @(negedge clk);
        while (clear_n !== 1'b0 && n < 50) begin
            @(negedge clk);
            n++;
        end
        gap = n;
        n = 0;
        while (clear_n === 1'b0 && n < 50) begin
            @(negedge clk);
            n++;
        end
        check("clear cycles", CLR_CYC, n);
        n = 0;
        while (run_n === 1'b0 && n < 30000) begin
            if (blank !== !latch) bad++;
            if (!latch && hold !== !blank) bad++;
            @(negedge clk);
            n++;
        end
        check("gate cycles", int'(GATE_UNITS[code]) * PU, n);
        check("gate blanking", 0, bad);
        check("count total", to_bcd(n), bcd_total);
        n = 0;
        while ((latch ? hold : blank) === 1'b0 && n < 100) begin
            if (run_n !== 1'b1 || blank !== 1'b0) bad++;
            @(negedge clk);
            n++;
        end
        check("pause cycles", PV * PU, n);
        check("pause display", 0, bad);
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        repeat (16) @(posedge clk);
        reset_n <= 1'b1;
        @(negedge clk);
        check("idle pins", 32'h19, {run_n, clear_n, hold, irq, blank});
        check("idle oe", 0, bus_oe);
        check("idle out", 0, bus_out);
        repeat (8) @(posedge clk);
        rchk("data", REG_DATA, 32'({ov, pf, PRESET}));
        rchk("unmapped", 5'h14, 32'h0);
        for (int k = 0; k < NLANE; k++) begin
            dig_en_n <= ~(7'h01 << k);
            repeat (5) @(posedge clk);
            lane_w = (k < NDIG) ? PRESET[k*4 +: 4] : {2'h0, ov, pf};
            check("lane oe", 32'(lane_w), 32'(bus_oe));
            if (k == NDIG)
                check("flag top", 0, 32'(bus_oe[3:2]));
            bus(1'b0, REG_STATUS, 32'h0);
            check("bus lines", {28'h0, ~lane_w}, rd & 32'hf);
        end
        dig_en_n <= 7'h00;
        repeat (5) @(posedge clk);
        check("parallel oe", 32'h7, 32'(bus_oe));
        dig_en_n <= 7'h7f;
        bus(1'b1, REG_IRQ_MASK, 32'h3);
        rchk("irq mask", REG_IRQ_MASK, 32'h3);
        for (int c = 0; c < 5; c++) begin
            gate_sel <= 3'(c);
            repeat (4) @(posedge clk);
            bus(1'b1, REG_CTRL, 32'h2);
            run_cycle(c, 1'b0);
            wait_idle();
        end
        check("irq set", 1, 32'(irq));
        rchk("irq stat", REG_IRQ_STAT, 32'h3);
        bus(1'b1, REG_IRQ_STAT, 32'h3);
        repeat (2) @(negedge clk);
        check("irq clear", 0, 32'(irq));
        bus(1'b1, REG_IRQ_MASK, 32'h0);
        gate_sel <= 3'h1;
        on_off_n <= 1'b0;
        fork
            begin
                repeat (2) @(posedge clk);
                on_off_n <= 1'b1;
            end
        join_none
        run_cycle(1, 1'b0);
        check("single gate", 1, 32'(clear_n));
        wait_idle();
        check("irq masked", 0, 32'(irq));
        rchk("irq stat", REG_IRQ_STAT, 32'h3);
        gate_sel <= 3'h0;
        on_off_n <= 1'b0;
        run_cycle(0, 1'b0);
        run_cycle(0, 1'b0);
        check("repeat gap", 0, gap);
        fork
            begin
                @(posedge clk);
                on_off_n <= 1'b1;
            end
        join_none
        run_cycle(0, 1'b0);
        wait_idle();
        repeat (20) @(posedge clk);
        rchk("stops", REG_STATUS, 32'h28f);
        pf <= 1'b0;
        ov <= 1'b1;
        gate_sel <= 3'h1;
        bus(1'b1, REG_CTRL, 32'h1);
        @(negedge clk);
        check("latch blank", 0, 32'(blank));
        bus(1'b1, REG_CTRL, 32'h3);
        run_cycle(1, 1'b1);
        wait_idle();
        rchk("latched", REG_DATA, 32'({2'b10, to_bcd(20)}));
        gate_sel <= 3'h2;
        bus(1'b1, REG_CTRL, 32'h3);
        repeat (60) @(posedge clk);
        check("counting", 0, 32'(run_n));
        rchk("held", REG_DATA, 32'({2'b10, to_bcd(20)}));
        wait_idle();
        rchk("new total", REG_DATA, 32'({2'b10, to_bcd(200)}));
        report_and_stop();
    end
endmodule // tb_top
